// >>> dv/bss_boot_select_checker.sv
`timescale 1ns/10ps
`include "bss_regs.svh"
module bss_boot_select_checker (
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        EXT_ACCESS_STRAP,
   input wire logic        PROG_STORE_STROBE,
   input wire logic        LOADER_JUMP_FUSE,
   input wire logic        SBV_WE,
   input wire logic        BOOT_VALID,
   input wire logic [15:0] BOOT_ADDR,
   input wire logic [1:0]  BOOT_SRC,
   input wire logic        FETCH_INTERNAL,
   input wire logic [15:0] API_ADDR,
   input wire logic [7:0]  SOFT_BOOT_VECTOR,
   input wire logic [7:0]  BOOT_STATUS_BYTE,
   input wire logic [7:0]  SOFTWARE_LOCK_BYTE,
   input wire logic        ISP_PROG_ALLOW,
   input wire logic        ISP_VERIFY_ALLOW
);
   logic [2:0] strap_s;
   logic       forced;
   // Capture straps on every reset edge; the last one is the reset fall
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         strap_s <= {EXT_ACCESS_STRAP, PROG_STORE_STROBE, LOADER_JUMP_FUSE};
      end
   end
   assign forced = strap_s[2] & ~strap_s[1];
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_fetch_strap: assert property (FETCH_INTERNAL == EXT_ACCESS_STRAP)
      else $error("fetch source differs from strap");
   a_reset_values: assert property ($fell(RST) |-> !BOOT_VALID
      && SOFT_BOOT_VECTOR == 8'hFC && BOOT_STATUS_BYTE == 8'hFF && SOFTWARE_LOCK_BYTE == 8'hFF)
      else $error("bad values after reset");
   a_valid_delay: assert property ($fell(RST) && CE |-> ##[1:2] BOOT_VALID)
      else $error("boot decision late");
   a_strap_loader: assert property ($rose(BOOT_VALID) && forced |->
      BOOT_SRC == bss_pkg::BSS_SRC_LOADER && BOOT_ADDR == `BSS_LOADER_ADDR)
      else $error("strap did not force loader");
   a_fuse_loader: assert property ($rose(BOOT_VALID) && !forced && !strap_s[0] |->
      BOOT_SRC == bss_pkg::BSS_SRC_LOADER && BOOT_ADDR == `BSS_LOADER_ADDR)
      else $error("cleared fuse did not pick loader");
   a_vector_boot: assert property ($rose(BOOT_VALID) && !forced && strap_s[0]
      && BOOT_STATUS_BYTE != 8'h00 |-> BOOT_SRC == bss_pkg::BSS_SRC_CUST
      && BOOT_ADDR == {SOFT_BOOT_VECTOR, 8'h00}) else $error("vector boot wrong");
   a_boot_stands: assert property (BOOT_VALID |=> BOOT_VALID && $stable(BOOT_ADDR)
      && $stable(BOOT_SRC)) else $error("boot outputs moved");
   a_lock_decode: assert property (ISP_PROG_ALLOW == (&SOFTWARE_LOCK_BYTE[1:0])
      && ISP_VERIFY_ALLOW == SOFTWARE_LOCK_BYTE[0]) else $error("lock decode wrong");
   a_reserved_set: assert property (SOFTWARE_LOCK_BYTE[7:2] == 6'h3F)
      else $error("reserved lock bits cleared");
   a_vector_locked: assert property (SBV_WE && CE && SOFTWARE_LOCK_BYTE[1:0] != 2'h3
      |=> $stable(SOFT_BOOT_VECTOR)) else $error("locked vector changed");
   a_api_entry: assert property (API_ADDR == 16'hFFF0)
      else $error("service entry wrong");
   c_loader: cover property ($rose(BOOT_VALID) && BOOT_SRC == 2'h1);
   c_vector: cover property ($rose(BOOT_VALID) && BOOT_SRC == 2'h2);
   c_locked: cover property (SBV_WE && SOFTWARE_LOCK_BYTE[1:0] != 2'h3);
endmodule // bss_boot_select_checker
bind bss_boot_select bss_boot_select_checker u_chk (.*);

// >>> dv/bss_strap_model.sv
`timescale 1ns/10ps
module bss_strap_model (
   input  wire logic ea_tie,
   input  wire logic force_low,
   input  wire logic RST,
   output logic      EXT_ACCESS_STRAP,
   output logic      PROG_STORE_STROBE
);
   // Access strap is a board tie, held steady
   assign EXT_ACCESS_STRAP  = ea_tie;
   // Strobe pulled low only while reset stands, back to pull-up as it falls
   assign PROG_STORE_STROBE = !(force_low && RST);
endmodule // bss_strap_model

// >>> dv/tb.sv
`timescale 1ns/10ps
`include "bss_regs.svh"
module tb;
   logic        REF_CLK = 1'b0, RST = 1'b1, CE = 1'b1, LOADER_JUMP_FUSE = 1'b1, API_CALL = 1'b0;
   logic        SBV_WE = 1'b0, BSB_WE = 1'b0, LOCK_WE = 1'b0, ea = 1'b1, frc = 1'b0, look = 1'b0;
   logic [7:0]  WDATA = 8'h00, soft_boot_vector, boot_status_byte, lock, r, id = `BSS_ID_MFR, ID_BYTE;
   logic [1:0]  ID_SEL = 2'h0, e_src, BOOT_SRC;
   logic [15:0] e_addr, BOOT_ADDR, API_ADDR;
   logic [7:0]  SOFT_BOOT_VECTOR, BOOT_STATUS_BYTE, SOFTWARE_LOCK_BYTE;
   logic        EXT_ACCESS_STRAP, PROG_STORE_STROBE, BOOT_VALID, FETCH_INTERNAL;
   logic        ISP_PROG_ALLOW, ISP_VERIFY_ALLOW;
   logic [7:0]  ids [4] = '{`BSS_ID_MFR, `BSS_ID_FAMILY, `BSS_ID_MEM, `BSS_ID_NAME};
   logic [53:0] q [$];
   int          fails = 0, n_compared = 0;
   bss_boot_select DUT (.*);
   bss_strap_model u_board (.ea_tie(ea), .force_low(frc), .*);
   // Clock and watchdog
   always #10 REF_CLK = ~REF_CLK;
   initial begin
      #40000;
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out();
   end
   // Output watcher: compares oldest note
   always @(negedge REF_CLK) begin
      if (look) begin
         look <= 1'b0;
         n_compared++;
         if ({BOOT_VALID, BOOT_SRC, BOOT_ADDR, SOFT_BOOT_VECTOR, BOOT_STATUS_BYTE,
              SOFTWARE_LOCK_BYTE, ISP_PROG_ALLOW, ISP_VERIFY_ALLOW, FETCH_INTERNAL,
              ID_BYTE} !== q.pop_front()) begin
            $display("unexpected at %0t: outputs differ from note", $time);
            fails++;
         end
      end
   end
   task automatic note();
      @(posedge REF_CLK);
      q.push_back({1'b1, e_src, e_addr, soft_boot_vector, boot_status_byte, lock, &lock[1:0], lock[0], ea, id});
      look <= 1'b1;
   endtask
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge REF_CLK);
      WDATA <= d;
      {SBV_WE, BSB_WE, LOCK_WE} <= 3'h4 >> k;
      @(posedge REF_CLK);
      {SBV_WE, BSB_WE, LOCK_WE} <= 3'h0;
   endtask
   task automatic boot(input logic a, input logic f, input logic j);
      @(posedge REF_CLK);
      {RST, ea, frc, LOADER_JUMP_FUSE} <= {1'b1, a, f, j};
      repeat (4) @(posedge REF_CLK);
      RST <= 1'b0;
      for (int k = 0; k < 6 && BOOT_VALID !== 1'b1; k++) @(negedge REF_CLK);
      {soft_boot_vector, boot_status_byte, lock} = {8'hFC, 8'hFF, 8'hFF};
      e_src  = ((a && f) || !j) ? 2'h1 : 2'h2;
      e_addr = ((a && f) || !j) ? `BSS_LOADER_ADDR : {soft_boot_vector, 8'h00};
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'h1B2A4DFA));
      for (int i = 0; i < 4; i++) begin
         boot(i[1], i[0], i != 1);
         note();
         $display("boot case %0d done", i);
      end
      r = 8'($urandom);
      wr(0, r);
      soft_boot_vector = r;
      note();
      // Clock enable low: a write must not land
      @(posedge REF_CLK);
      CE <= 1'b0;
      wr(1, 8'h00);
      note();
      CE <= 1'b1;
      wr(1, 8'h00);
      boot_status_byte = 8'h00;
      note();
      wr(2, 8'hFD);
      lock = 8'hFD;
      note();
      wr(0, ~r);
      note();
      wr(1, 8'hFF);
      note();
      wr(2, 8'hFC);
      lock = 8'hFC;
      note();
      $display("lock test done");
      for (int i = 0; i < 4; i++) begin
         @(posedge REF_CLK);
         ID_SEL <= i[1:0];
         id = ids[i];
         note();
      end
      $display("identity test done");
      @(posedge REF_CLK);
      close_out();
   end
endmodule // tb

// >>> hw/bss_boot_select.sv
`timescale 1ns/10ps
`include "bss_regs.svh"
module bss_boot_select (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        EXT_ACCESS_STRAP,
   input  wire logic        PROG_STORE_STROBE,
   input  wire logic        LOADER_JUMP_FUSE,
   input  wire logic        SBV_WE,
   input  wire logic        BSB_WE,
   input  wire logic        LOCK_WE,
   input  wire logic [7:0]  WDATA,
   input  wire logic [1:0]  ID_SEL,
   input  wire logic        API_CALL,
   output logic             BOOT_VALID,
   output logic      [15:0] BOOT_ADDR,
   output logic      [1:0]  BOOT_SRC,
   output logic             FETCH_INTERNAL,
   output logic      [15:0] API_ADDR,
   output logic      [7:0]  SOFT_BOOT_VECTOR,
   output logic      [7:0]  BOOT_STATUS_BYTE,
   output logic      [7:0]  SOFTWARE_LOCK_BYTE,
   output logic             ISP_PROG_ALLOW,
   output logic             ISP_VERIFY_ALLOW,
   output logic      [7:0]  ID_BYTE
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      bss_pkg::bss_state_e state;
      logic                strap_ea;
      logic                strap_program_store_strobe;
      logic                boot_valid;
      logic [15:0]         boot_addr;
      bss_pkg::bss_src_e   boot_src;
      logic [7:0]          soft_boot_vector;
      logic [7:0]          boot_status_byte;
      logic [7:0]          lock;
      logic [7:0]          id_byte;
   } bss_state_s;

   bss_state_s st_r;
   bss_state_s st_nxt;
   logic       prog_allow;
   logic       verify_allow;
   logic [7:0] id_raw;

   // Write permission follows lock; reserved bits never cleared
   function automatic logic [7:0] lock_merge(input logic [7:0] d);
      lock_merge = d | `BSS_LOCK_RSVD_MASK;
   endfunction

   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   bss_lock_decode u_lock (
      .lock_byte    (st_r.lock),
      .prog_allow   (prog_allow),
      .verify_allow (verify_allow)
   );

   bss_id_rom u_id (
      .sel     (ID_SEL),
      .id_byte (id_raw)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.id_byte = id_raw;
      case (st_r.state)
         bss_pkg::BSS_IN_RESET: begin
            st_nxt.boot_valid = 1'b0;
            // Straps already held from the last reset edge
            st_nxt.state      = bss_pkg::BSS_DECIDE;
         end
         bss_pkg::BSS_DECIDE: begin
            // Hardware decision before first fetch
            if (st_r.strap_ea && !st_r.strap_program_store_strobe) begin
               st_nxt.boot_src  = bss_pkg::BSS_SRC_LOADER;
               st_nxt.boot_addr = `BSS_LOADER_ADDR;
            end else if (!LOADER_JUMP_FUSE) begin
               st_nxt.boot_src  = bss_pkg::BSS_SRC_LOADER;
               st_nxt.boot_addr = `BSS_LOADER_ADDR;
            end else if (st_r.boot_status_byte == `BSS_BSB_APP) begin
               st_nxt.boot_src  = bss_pkg::BSS_SRC_APP;
               st_nxt.boot_addr = `BSS_APP_ADDR;
            end else begin
               st_nxt.boot_src  = bss_pkg::BSS_SRC_CUST;
               st_nxt.boot_addr = {st_r.soft_boot_vector, `BSS_VEC_LOW};
            end
            st_nxt.boot_valid = 1'b1;
            st_nxt.state      = bss_pkg::BSS_RUNNING;
         end
         bss_pkg::BSS_RUNNING: begin
            // Software updates to the boot bytes; vector and status gated by lock level, lock byte writes always taken
            if (SBV_WE && prog_allow) begin
               st_nxt.soft_boot_vector = WDATA;
            end
            if (BSB_WE && prog_allow) begin
               st_nxt.boot_status_byte = WDATA;
            end
            if (LOCK_WE) begin
               st_nxt.lock = st_r.lock & lock_merge(WDATA);
            end
         end
         default: begin
            st_nxt.state = bss_pkg::BSS_IN_RESET;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Straps track the pins while reset stands; last reset edge is the fall
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st_r.state      <= bss_pkg::BSS_IN_RESET;
         st_r.strap_ea   <= EXT_ACCESS_STRAP;
         st_r.strap_program_store_strobe <= PROG_STORE_STROBE;
         st_r.boot_valid <= 1'b0;
         st_r.boot_addr  <= `BSS_APP_ADDR;
         st_r.boot_src   <= bss_pkg::BSS_SRC_APP;
         st_r.soft_boot_vector        <= `BSS_SBV_RST;
         st_r.boot_status_byte        <= `BSS_BSB_RST;
         st_r.lock       <= `BSS_LOCK_RST;
         st_r.id_byte    <= `BSS_ID_MFR;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign BOOT_VALID         = st_r.boot_valid;
   assign BOOT_ADDR          = st_r.boot_addr;
   assign BOOT_SRC           = st_r.boot_src;
   assign FETCH_INTERNAL     = EXT_ACCESS_STRAP;
   assign API_ADDR           = `BSS_API_ENTRY;
   assign SOFT_BOOT_VECTOR   = st_r.soft_boot_vector;
   assign BOOT_STATUS_BYTE   = st_r.boot_status_byte;
   assign SOFTWARE_LOCK_BYTE = st_r.lock;
   assign ISP_PROG_ALLOW     = prog_allow;
   assign ISP_VERIFY_ALLOW   = verify_allow;
   assign ID_BYTE            = st_r.id_byte;
endmodule // bss_boot_select

// >>> hw/bss_id_rom.sv
`timescale 1ns/10ps
`include "bss_regs.svh"
// ----------------------------------------
// Identity byte copies
// ----------------------------------------
module bss_id_rom (
   input  wire logic [1:0] sel,
   output logic      [7:0] id_byte
);
   // Constant table lookup
   always_comb begin
      case (sel)
         `BSS_ID_SEL_MFR:    id_byte = `BSS_ID_MFR;
         `BSS_ID_SEL_FAMILY: id_byte = `BSS_ID_FAMILY;
         `BSS_ID_SEL_MEM:    id_byte = `BSS_ID_MEM;
         `BSS_ID_SEL_NAME:   id_byte = `BSS_ID_NAME;
         default:            id_byte = `BSS_ID_MFR;
      endcase
   end
endmodule // bss_id_rom

// >>> hw/bss_lock_decode.sv
`timescale 1ns/10ps
`include "bss_regs.svh"
// ----------------------------------------
// User lock field decode
// ----------------------------------------
module bss_lock_decode (
   input  wire logic [7:0] lock_byte,
   output logic            prog_allow,
   output logic            verify_allow
);
   // Lock permissions from bits 1-0
   always_comb begin
      prog_allow   = lock_byte[`BSS_LOCK_HI_BIT] & lock_byte[`BSS_LOCK_LO_BIT];
      verify_allow = lock_byte[`BSS_LOCK_LO_BIT];
   end
endmodule // bss_lock_decode

// >>> include/bss_pkg.sv
package bss_pkg;
   // Boot decision sequencer states, Gray along the path
   typedef enum logic [1:0] {
      BSS_IN_RESET = 2'h0,
      BSS_DECIDE   = 2'h1,
      BSS_RUNNING  = 2'h3
   } bss_state_e;

   // Source of the first fetch
   typedef enum logic [1:0] {
      BSS_SRC_APP    = 2'h0,
      BSS_SRC_LOADER = 2'h1,
      BSS_SRC_CUST   = 2'h2
   } bss_src_e;
endpackage

// >>> include/bss_regs.svh
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH
// ----------------------------------------
// Reset values of the boot bytes, and the status byte value that selects the application
// ----------------------------------------
`define BSS_SBV_RST        8'hFC
`define BSS_BSB_RST        8'hFF
`define BSS_LOCK_RST       8'hFF
`define BSS_BSB_APP        8'h00
// ----------------------------------------
// Addresses and field positions
// ----------------------------------------
`define BSS_APP_ADDR       16'h0000
`define BSS_LOADER_ADDR    16'hF800
`define BSS_API_ENTRY      16'hFFF0
`define BSS_VEC_LOW        8'h00
`define BSS_LOCK_LO_BIT     0
`define BSS_LOCK_HI_BIT    1
`define BSS_LOCK_RSVD_MASK 8'hFC
// ----------------------------------------
// Identity bytes (values arbitrary)
// ----------------------------------------
`define BSS_ID_MFR         8'h11
`define BSS_ID_FAMILY      8'h22
`define BSS_ID_MEM         8'h33
`define BSS_ID_NAME        8'h44
`define BSS_ID_SEL_MFR     2'h0
`define BSS_ID_SEL_FAMILY  2'h1
`define BSS_ID_SEL_MEM     2'h2
`define BSS_ID_SEL_NAME    2'h3
`endif
